// file: design/lid_pkg.sv
package lid_pkg;

  typedef enum logic [4:0] {
    CL_ILLEGAL, CL_PORT_IN, CL_PORT_OUT, CL_TABLE_LOOKUP_BYTE, CL_LEA, CL_LDPTR,
    CL_FLAGS, CL_ALU, CL_TEST, CL_UNARY, CL_MULDIV, CL_IMUL3, CL_INCDEC,
    CL_ADJUST, CL_CONVERT, CL_SHIFT, CL_STRING, CL_JUMP
  } lid_class_t;

  typedef struct packed {
    lid_class_t cls;
    logic [2:0] sub;
    logic mrm;
    logic [2:0] imm;
    logic [7:0] cmin;
    logic [7:0] cmax;
    logic [7:0] per;
    logic bad;
  } lid_dec_t;

  // addressing byte fields, byte counts, prefix count limit and AAM/AAD base
  localparam logic [1:0] MOD_MEM = 2'h0, MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2, MOD_REG = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;
  localparam logic [2:0] N_NONE = 3'h0, N_ONE = 3'h1;
  localparam logic [2:0] N_TWO = 3'h2, N_FOUR = 3'h4;
  localparam logic [1:0] SEG_N_MAX = 2'h3;
  localparam logic [7:0] ASCII_MD_BASE = 8'h0a;

  // opcode patterns
  localparam logic [7:0] OP_SEG_PFX = 8'b001??110;
  localparam logic [7:0] OP_REP_PFX = 8'b1111001?;
  localparam logic [7:0] OP_IN_DIR = 8'b1110010?, OP_IN_IND = 8'b1110110?;
  localparam logic [7:0] OP_OUT_DIR = 8'b1110011?, OP_OUT_IND = 8'b1110111?;
  localparam logic [7:0] OP_TABLE_LOOKUP_BYTE = 8'hd7, OP_LEA = 8'h8d;
  localparam logic [7:0] OP_LDPTR = 8'b1100010?, OP_FLAGS = 8'b100111??;
  localparam logic [7:0] OP_ALU_RM = 8'b00???0??, OP_ALU_ACC = 8'b00???10?;
  localparam logic [7:0] OP_GRP1 = 8'b100000??, OP_TEST_RM = 8'b1000010?;
  localparam logic [7:0] OP_TEST_ACC = 8'b1010100?, OP_GRP3 = 8'b1111011?;
  localparam logic [7:0] OP_GRP5 = 8'b1111111?, OP_INCDEC_R = 8'b0100????;
  localparam logic [7:0] OP_IMUL3 = 8'b011010?1, OP_ASCII_MD = 8'b1101010?;
  localparam logic [7:0] OP_ADJUST = 8'b001??111, OP_CONVERT = 8'b1001100?;
  localparam logic [7:0] OP_SHIFT1 = 8'b1101000?, OP_SHIFTCL = 8'b1101001?;
  localparam logic [7:0] OP_SHIFTIMM = 8'b1100000?;
  localparam logic [7:0] OP_STRING_MOVE = 8'b1010010?, OP_STRING_COMPARE = 8'b1010011?;
  localparam logic [7:0] OP_STRING_SCAN = 8'b1010111?, OP_STRING_LOAD = 8'b1010110?;
  localparam logic [7:0] OP_STRING_STORE = 8'b1010101?, OP_INS = 8'b0110110?;
  localparam logic [7:0] OP_STRING_PORT_OUT = 8'b0110111?;
  localparam logic [7:0] OP_JMP_SHORT = 8'heb, OP_JMP_NEAR = 8'he9;
  localparam logic [7:0] OP_JMP_FAR = 8'hea;

  // processor clocks
  localparam logic [7:0] T_NONE = 8'h0, T_PFX = 8'h2;
  localparam logic [7:0] T_IN_DIR = 8'ha, T_IN_IND = 8'h8;
  localparam logic [7:0] T_OUT_DIR = 8'h9, T_OUT_IND = 8'h7;
  localparam logic [7:0] T_TABLE_LOOKUP_BYTE = 8'hb, T_LEA = 8'h6, T_LDPTR = 8'h12;
  localparam logic [7:0] T_PUSH_FLAG_WORD = 8'h9, T_POP_FLAG_WORD = 8'h8;
  localparam logic [7:0] T_ACC_HIGH_TO_FLAGS = 8'h3, T_FLAGS_TO_ACC_HIGH = 8'h2;
  localparam logic [7:0] T_ALU_R = 8'h3, T_ALU_M = 8'ha;
  localparam logic [7:0] T_ACC_B = 8'h3, T_ACC_W = 8'h4;
  localparam logic [7:0] T_IMM_R = 8'h4, T_IMM_M = 8'h10;
  localparam logic [7:0] T_TSTI_R = 8'h4, T_TSTI_M = 8'ha;
  localparam logic [7:0] T_UN_R = 8'h3, T_UN_M = 8'ha;
  localparam logic [7:0] T_INC_R = 8'h3, T_INC_M = 8'hf, T_INC_REG = 8'h3;
  localparam logic [7:0] T_DAA = 8'h4, T_DAS = 8'h4;
  localparam logic [7:0] T_AAA = 8'h8, T_AAS = 8'h7;
  localparam logic [7:0] T_AAM = 8'h13, T_AAD = 8'hf;
  localparam logic [7:0] T_CBW = 8'h2, T_CWD = 8'h4;
  localparam logic [7:0] T_MUL = 8'h1a, T_MUL_S = 8'h2;
  localparam logic [7:0] T_SIGNED_MULTIPLY = 8'h19, T_SIGNED_MULTIPLY_S = 8'h3;
  localparam logic [7:0] T_DIV = 8'h1d, T_DIV_S = 8'h0;
  localparam logic [7:0] T_SIGNED_DIVIDE = 8'h2c, T_SIGNED_DIVIDE_S = 8'h8;
  localparam logic [7:0] T_MD_WORD = 8'h9, T_MD_MEM = 8'h6;
  localparam logic [7:0] T_IM3_R = 8'h16, T_IM3_M = 8'h1d, T_IM3_S = 8'h3;
  localparam logic [7:0] T_SH1_R = 8'h2, T_SH1_M = 8'hf;
  localparam logic [7:0] T_SHN_R = 8'h5, T_SHN_M = 8'h11, T_SHN_N = 8'h1;
  localparam logic [7:0] T_STRING_MOVE = 8'he, T_STRING_COMPARE = 8'h16, T_STRING_SCAN = 8'hf;
  localparam logic [7:0] T_STRING_LOAD = 8'hc, T_STRING_STORE = 8'ha;
  localparam logic [7:0] T_INS = 8'he, T_STRING_PORT_OUT = 8'he;
  localparam logic [7:0] T_RMOVS_B = 8'h8, T_RMOVS_N = 8'h8;
  localparam logic [7:0] T_RCMPS_B = 8'h5, T_RCMPS_N = 8'h16;
  localparam logic [7:0] T_RSCAS_B = 8'h5, T_RSCAS_N = 8'hf;
  localparam logic [7:0] T_RLODS_B = 8'h6, T_RLODS_N = 8'hb;
  localparam logic [7:0] T_RSTOS_B = 8'h6, T_RSTOS_N = 8'h9;
  localparam logic [7:0] T_RIO_B = 8'h8, T_RIO_N = 8'h8;
  localparam logic [7:0] T_JMP = 8'he, T_JI_R = 8'hb, T_JI_M = 8'h11;
  localparam logic [7:0] T_JFI = 8'h1a;

endpackage

// file: design/lid_decoder.sv
`timescale 1ns/1ns
module lid_decoder (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // instruction byte stream
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  output logic byteReady,
  // decoded instruction
  output logic instrValid,
  input wire logic instrReady,
  output lid_pkg::lid_class_t opClass,
  output logic [7:0] opCode,
  output logic [2:0] subOp,
  output logic opWidth,
  output logic opDir,
  output logic [1:0] modField,
  output logic [2:0] regField,
  output logic [2:0] rmField,
  output logic regOperand,
  output logic [15:0] dispValue,
  output logic [31:0] immValue,
  output logic segOverride,
  output logic [1:0] segSel,
  output logic repActive,
  output logic repZ,
  output logic illegal,
  // execution clocks
  output logic [7:0] clkMin,
  output logic [7:0] clkMax,
  output logic [7:0] clkPerCount
);
  import lid_pkg::*;

  typedef enum logic [2:0] {
    ST_OPC, ST_MRM, ST_DISP, ST_IMM, ST_OUT
  } lid_state_t;

  typedef struct packed {
    lid_state_t st;
    logic [7:0] op;
    logic [7:0] mrm;
    logic [2:0] cnt;
    logic [15:0] disp;
    logic [31:0] imm;
    logic [1:0] segN;
    logic [1:0] seg;
    logic rep;
    logic repZ;
    logic oValid;
    lid_class_t oCls;
    logic [2:0] oSub;
    logic oBad;
    logic [7:0] oMin;
    logic [7:0] oMax;
    logic [7:0] oPer;
    logic oRep;
  } lid_regs_t;

  lid_regs_t s_r, s_nxt;

  function automatic lid_dec_t mk(
    input lid_class_t c,
    input logic [2:0] sub,
    input logic r,
    input logic [2:0] n,
    input logic [7:0] lo,
    input logic [7:0] hi,
    input logic [7:0] per
  );
    lid_dec_t d;
    d.cls = c;
    d.sub = sub;
    d.mrm = r;
    d.imm = n;
    d.cmin = lo;
    d.cmax = hi;
    d.per = per;
    d.bad = 1'b0;
    return d;
  endfunction

  function automatic lid_dec_t strOp(
    input logic [2:0] sub,
    input logic rep,
    input logic [7:0] one,
    input logic [7:0] rb,
    input logic [7:0] rn
  );
    lid_dec_t d;
    if (rep) begin
      d = mk(CL_STRING, sub, 1'b0, N_NONE, rb, rb, rn);
    end else begin
      d = mk(CL_STRING, sub, 1'b0, N_NONE, one, one, T_NONE);
    end
    return d;
  endfunction

  // displacement bytes after the addressing byte
  function automatic logic [2:0] dispLen(input logic [7:0] m);
    logic [2:0] n;
    n = N_NONE;
    if (m[7:6] == MOD_DISP8) begin
      n = N_ONE;
    end else if (m[7:6] == MOD_DISP16) begin
      n = N_TWO;
    end else if (m[7:6] == MOD_MEM && m[2:0] == RM_DIRECT) begin
      n = N_TWO;
    end
    return n;
  endfunction

  function automatic lid_dec_t decodeOp(
    input logic [7:0] op,
    input logic [7:0] m,
    input logic rep
  );
    lid_dec_t d;
    logic w;
    logic isReg;
    logic [2:0] f;
    logic [7:0] t;
    logic [7:0] sp;
    w = op[0];
    isReg = (m[7:6] == MOD_REG);
    f = m[5:3];
    t = T_NONE;
    sp = T_NONE;
    d = mk(CL_ILLEGAL, 3'h0, 1'b0, N_NONE, T_NONE, T_NONE, T_NONE);
    d.bad = 1'b1;
    casez (op)
      OP_IN_DIR: d = mk(CL_PORT_IN, 3'h0, 1'b0, N_ONE, T_IN_DIR, T_IN_DIR,
        T_NONE);
      OP_IN_IND: d = mk(CL_PORT_IN, 3'h1, 1'b0, N_NONE, T_IN_IND, T_IN_IND,
        T_NONE);
      OP_OUT_DIR: d = mk(CL_PORT_OUT, 3'h0, 1'b0, N_ONE, T_OUT_DIR,
        T_OUT_DIR, T_NONE);
      OP_OUT_IND: d = mk(CL_PORT_OUT, 3'h1, 1'b0, N_NONE, T_OUT_IND,
        T_OUT_IND, T_NONE);
      OP_TABLE_LOOKUP_BYTE: d = mk(CL_TABLE_LOOKUP_BYTE, 3'h0, 1'b0, N_NONE, T_TABLE_LOOKUP_BYTE, T_TABLE_LOOKUP_BYTE,
        T_NONE);
      OP_LEA: d = mk(CL_LEA, 3'h0, 1'b1, N_NONE, T_LEA, T_LEA,
        T_NONE);
      OP_LDPTR: begin
        d = mk(CL_LDPTR, {2'h0, ~w}, 1'b1, N_NONE, T_LDPTR, T_LDPTR, T_NONE);
        d.bad = isReg;
      end
      OP_FLAGS: begin
        case (op[1:0])
          2'h0: t = T_PUSH_FLAG_WORD;
          2'h1: t = T_POP_FLAG_WORD;
          2'h2: t = T_ACC_HIGH_TO_FLAGS;
          default: t = T_FLAGS_TO_ACC_HIGH;
        endcase
        d = mk(CL_FLAGS, {1'b0, op[1:0]}, 1'b0, N_NONE, t, t, T_NONE);
      end
      OP_ALU_RM: begin
        t = isReg ? T_ALU_R : T_ALU_M;
        d = mk(CL_ALU, op[5:3], 1'b1, N_NONE, t, t, T_NONE);
      end
      OP_ALU_ACC: begin
        t = w ? T_ACC_W : T_ACC_B;
        d = mk(CL_ALU, op[5:3], 1'b0, w ? N_TWO : N_ONE, t, t,
          T_NONE);
      end
      OP_GRP1: begin
        t = isReg ? T_IMM_R : T_IMM_M;
        d = mk(CL_ALU, f, 1'b1, (op[1:0] == 2'h1) ? N_TWO : N_ONE, t, t,
          T_NONE);
      end
      OP_TEST_RM: begin
        t = isReg ? T_ALU_R : T_ALU_M;
        d = mk(CL_TEST, 3'h0, 1'b1, N_NONE, t, t, T_NONE);
      end
      OP_TEST_ACC: begin
        t = w ? T_ACC_W : T_ACC_B;
        d = mk(CL_TEST, 3'h1, 1'b0, w ? N_TWO : N_ONE, t, t,
          T_NONE);
      end
      OP_GRP3: begin
        case (f)
          3'h0: begin
            t = isReg ? T_TSTI_R : T_TSTI_M;
            d = mk(CL_TEST, 3'h2, 1'b1, w ? N_TWO : N_ONE, t, t,
              T_NONE);
          end
          3'h2, 3'h3: begin
            t = isReg ? T_UN_R : T_UN_M;
            d = mk(CL_UNARY, f, 1'b1, N_NONE, t, t, T_NONE);
          end
          3'h4, 3'h5, 3'h6, 3'h7: begin
            case (f)
              3'h4: {t, sp} = {T_MUL, T_MUL_S};
              3'h5: {t, sp} = {T_SIGNED_MULTIPLY, T_SIGNED_MULTIPLY_S};
              3'h6: {t, sp} = {T_DIV, T_DIV_S};
              default: {t, sp} = {T_SIGNED_DIVIDE, T_SIGNED_DIVIDE_S};
            endcase
            t = t + (w ? T_MD_WORD : T_NONE);
            t = t + (isReg ? T_NONE : T_MD_MEM);
            d = mk(CL_MULDIV, f, 1'b1, N_NONE, t, t + sp, T_NONE);
          end
          default: d.mrm = 1'b1;
        endcase
      end
      OP_IMUL3: begin
        t = isReg ? T_IM3_R : T_IM3_M;
        d = mk(CL_IMUL3, 3'h5, 1'b1, op[1] ? N_ONE : N_TWO, t, t + T_IM3_S,
          T_NONE);
      end
      OP_GRP5: begin
        case (f)
          3'h0, 3'h1: begin
            t = isReg ? T_INC_R : T_INC_M;
            d = mk(CL_INCDEC, f, 1'b1, N_NONE, t, t, T_NONE);
          end
          3'h4: begin
            t = isReg ? T_JI_R : T_JI_M;
            d = mk(CL_JUMP, 3'h3, 1'b1, N_NONE, t, t, T_NONE);
            d.bad = ~w;
          end
          3'h5: begin
            d = mk(CL_JUMP, 3'h4, 1'b1, N_NONE, T_JFI, T_JFI, T_NONE);
            d.bad = ~w | isReg;
          end
          default: d.mrm = 1'b1;
        endcase
      end
      OP_INCDEC_R: d = mk(CL_INCDEC, {2'h0, op[3]}, 1'b0, N_NONE,
        T_INC_REG, T_INC_REG, T_NONE);
      OP_ADJUST: begin
        case (op[4:3])
          2'h0: t = T_DAA;
          2'h1: t = T_DAS;
          2'h2: t = T_AAA;
          default: t = T_AAS;
        endcase
        d = mk(CL_ADJUST, {1'b0, op[4:3]}, 1'b0, N_NONE, t, t,
          T_NONE);
      end
      OP_ASCII_MD: begin
        t = w ? T_AAD : T_AAM;
        d = mk(CL_ADJUST, {2'h2, w}, 1'b0, N_ONE, t, t,
          T_NONE);
      end
      OP_CONVERT: begin
        t = w ? T_CWD : T_CBW;
        d = mk(CL_CONVERT, {2'h0, w}, 1'b0, N_NONE, t, t, T_NONE);
      end
      OP_SHIFT1: begin
        t = isReg ? T_SH1_R : T_SH1_M;
        d = mk(CL_SHIFT, f, 1'b1, N_NONE, t, t, T_NONE);
      end
      OP_SHIFTCL: begin
        t = isReg ? T_SHN_R : T_SHN_M;
        d = mk(CL_SHIFT, f, 1'b1, N_NONE, t, t, T_SHN_N);
      end
      OP_SHIFTIMM: begin
        t = isReg ? T_SHN_R : T_SHN_M;
        d = mk(CL_SHIFT, f, 1'b1, N_ONE, t, t, T_SHN_N);
      end
      OP_STRING_MOVE: d = strOp(3'h0, rep, T_STRING_MOVE, T_RMOVS_B, T_RMOVS_N);
      OP_STRING_COMPARE: d = strOp(3'h1, rep, T_STRING_COMPARE, T_RCMPS_B, T_RCMPS_N);
      OP_STRING_SCAN: d = strOp(3'h2, rep, T_STRING_SCAN, T_RSCAS_B, T_RSCAS_N);
      OP_STRING_LOAD: d = strOp(3'h3, rep, T_STRING_LOAD, T_RLODS_B, T_RLODS_N);
      OP_STRING_STORE: d = strOp(3'h4, rep, T_STRING_STORE, T_RSTOS_B, T_RSTOS_N);
      OP_INS: d = strOp(3'h5, rep, T_INS, T_RIO_B, T_RIO_N);
      OP_STRING_PORT_OUT: d = strOp(3'h6, rep, T_STRING_PORT_OUT, T_RIO_B, T_RIO_N);
      OP_JMP_SHORT: d = mk(CL_JUMP, 3'h0, 1'b0, N_ONE, T_JMP, T_JMP, T_NONE);
      OP_JMP_NEAR: d = mk(CL_JUMP, 3'h1, 1'b0, N_TWO, T_JMP, T_JMP, T_NONE);
      OP_JMP_FAR: d = mk(CL_JUMP, 3'h2, 1'b0, N_FOUR, T_JMP, T_JMP, T_NONE);
      default: ;
    endcase
    return d;
  endfunction

  lid_dec_t dec;
  logic [2:0] dl;
  logic fin;
  logic [7:0] pfx;

  always_comb begin
    s_nxt = s_r;
    dec = decodeOp(s_r.op, s_r.mrm, s_r.rep);
    dl = dispLen(s_r.mrm);
    fin = 1'b0;
    pfx = T_NONE;
    unique case (s_r.st)
      ST_OPC: begin
        if (byteValid) begin
          if (byteData ==? OP_SEG_PFX) begin
            s_nxt.seg = byteData[4:3];
            if (s_r.segN != SEG_N_MAX) begin
              s_nxt.segN = s_r.segN + 2'h1;
            end
          end else if (byteData ==? OP_REP_PFX) begin
            s_nxt.rep = 1'b1;
            s_nxt.repZ = byteData[0];
          end else begin
            s_nxt.op = byteData;
            dec = decodeOp(byteData, s_r.mrm, s_r.rep);
            if (dec.mrm) begin
              s_nxt.st = ST_MRM;
            end else if (dec.imm != N_NONE) begin
              s_nxt.st = ST_IMM;
            end else begin
              fin = 1'b1;
            end
          end
        end
      end
      ST_MRM: begin
        if (byteValid) begin
          s_nxt.mrm = byteData;
          dec = decodeOp(s_r.op, byteData, s_r.rep);
          dl = dispLen(byteData);
          if (dl != N_NONE) begin
            s_nxt.st = ST_DISP;
          end else if (dec.imm != N_NONE) begin
            s_nxt.st = ST_IMM;
          end else begin
            fin = 1'b1;
          end
        end
      end
      ST_DISP: begin
        if (byteValid) begin
          s_nxt.disp[{s_r.cnt[0], 3'h0} +: 8] = byteData;
          s_nxt.cnt = s_r.cnt + 3'h1;
          if (s_r.cnt + 3'h1 == dl) begin
            s_nxt.cnt = 3'h0;
            if (dec.imm != N_NONE) begin
              s_nxt.st = ST_IMM;
            end else begin
              fin = 1'b1;
            end
          end
        end
      end
      ST_IMM: begin
        if (byteValid) begin
          s_nxt.imm[{s_r.cnt[1:0], 3'h0} +: 8] = byteData;
          s_nxt.cnt = s_r.cnt + 3'h1;
          if (s_r.cnt + 3'h1 == dec.imm) begin
            fin = 1'b1;
          end
        end
      end
      ST_OUT: begin
        if (instrReady) begin
          // segment count, repeat flags and operands die with the instruction; seg keeps its last value, so segSel still shows it
          s_nxt.st = ST_OPC;
          s_nxt.oValid = 1'b0;
          s_nxt.segN = 2'h0;
          s_nxt.rep = 1'b0;
          s_nxt.repZ = 1'b0;
          s_nxt.mrm = 8'h0;
          s_nxt.cnt = 3'h0;
          s_nxt.disp = 16'h0;
          s_nxt.imm = 32'h0;
        end
      end
    endcase
    if (fin) begin
      // address calculation is already inside every figure
      dec = decodeOp(s_nxt.op, s_nxt.mrm, s_nxt.rep);
      pfx = 8'({6'h0, s_nxt.segN} * T_PFX);
      s_nxt.st = ST_OUT;
      s_nxt.cnt = 3'h0;
      s_nxt.oValid = 1'b1;
      s_nxt.oCls = dec.cls;
      s_nxt.oSub = dec.sub;
      s_nxt.oMin = dec.cmin + pfx;
      s_nxt.oMax = dec.cmax + pfx;
      s_nxt.oPer = dec.per;
      s_nxt.oRep = s_nxt.rep & (dec.cls == CL_STRING);
      s_nxt.oBad = dec.bad;
      if (s_nxt.op ==? OP_ASCII_MD) begin
        if (s_nxt.imm[7:0] != ASCII_MD_BASE) begin
          s_nxt.oBad = 1'b1;
        end
      end
      if (dec.mrm && s_nxt.mrm[7:6] == MOD_DISP8) begin
        s_nxt.disp[15:8] = {8{s_nxt.disp[7]}};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign byteReady = (s_r.st != ST_OUT);
  assign instrValid = s_r.oValid;
  assign opClass = s_r.oCls;
  assign opCode = s_r.op;
  assign subOp = s_r.oSub;
  assign opWidth = s_r.op[0];
  assign opDir = s_r.op[1];
  assign modField = s_r.mrm[7:6];
  assign regField = s_r.mrm[5:3];
  assign rmField = s_r.mrm[2:0];
  assign regOperand = (s_r.mrm[7:6] == MOD_REG);
  assign dispValue = s_r.disp;
  assign immValue = s_r.imm;
  assign segOverride = (s_r.segN != 2'h0);
  assign segSel = s_r.seg;
  assign repActive = s_r.oRep;
  assign repZ = s_r.repZ & s_r.oRep;
  assign illegal = s_r.oBad;
  assign clkMin = s_r.oMin;
  assign clkMax = s_r.oMax;
  assign clkPerCount = s_r.oPer;

endmodule

// file: sim/lid_decoder_asserts.sv
`timescale 1ns/1ns
module lid_decoder_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // handshakes
  input wire logic byteReady,
  input wire logic instrValid,
  input wire logic instrReady,
  // decoded fields
  input wire lid_pkg::lid_class_t opClass,
  input wire logic [7:0] opCode,
  input wire logic [1:0] modField,
  input wire logic regOperand,
  input wire logic segOverride,
  input wire logic repActive,
  input wire logic illegal,
  input wire logic [7:0] clkMin,
  input wire logic [7:0] clkMax,
  input wire logic [7:0] clkPerCount
);
  import lid_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic plain;
  assign plain = instrValid && !segOverride;

  a_busy_refuse: assert property (instrValid |-> !byteReady)
    else $error("byte taken while instruction held");
  a_held_stable: assert property (instrValid && !instrReady |=>
    instrValid && $stable(opCode) && $stable(clkMin))
    else $error("decoded output changed before accept");
  a_accept_free: assert property (instrValid && instrReady |=>
    !instrValid && byteReady)
    else $error("instruction not released after accept");
  a_ptr_mem_only: assert property (instrValid &&
    opClass == CL_LDPTR && modField == 2'h3 |-> illegal)
    else $error("pointer load with register operand accepted");
  a_reg_select: assert property (instrValid |->
    regOperand == (modField == 2'h3))
    else $error("register operand flag disagrees with mode");
  a_lea_clocks: assert property (plain && opCode == 8'h8d |->
    clkMin == 8'h06 && clkMax == 8'h06)
    else $error("address load clocks wrong");
  a_table_lookup_byte_clocks: assert property (plain && opCode == 8'hd7 |->
    clkMin == 8'h0b)
    else $error("table lookup clocks wrong");
  a_outind_clocks: assert property (plain &&
    opCode[7:1] == 7'h77 |-> clkMin == 8'h07)
    else $error("indirect output clocks wrong");
  a_rep_compare: assert property (plain && repActive &&
    opCode[7:1] == 7'h53 |-> clkMin == 8'h05 && clkPerCount == 8'h16)
    else $error("repeated compare clocks wrong");
  a_pfx_cleared: assert property (instrValid && instrReady |=>
    !segOverride)
    else $error("segment prefix outlived its instruction");

  c_repeat: cover property (instrValid && instrReady && repActive);
  c_segment: cover property (instrValid && segOverride);
  c_illegal: cover property (instrValid && illegal);
endmodule

bind lid_decoder lid_decoder_asserts i_lid_decoder_asserts (.clk_sys,
  .reset, .byteReady, .instrValid, .instrReady, .opClass, .opCode,
  .modField, .regOperand, .segOverride, .repActive, .illegal, .clkMin,
  .clkMax, .clkPerCount);

// file: sim/lid_byte_source.sv
`timescale 1ns/1ns
module lid_byte_source (
  // clock
  input wire logic clk_sys,
  // byte stream
  input wire logic byteReady,
  output logic byteValid,
  output logic [7:0] byteData
);
  logic [7:0] q[$];
  int seed = 32'h8188;
  initial begin
    byteValid = 1'b0;
    byteData = 8'h00;
  end
  // offer held until taken; idle data toggles so stale bytes never match
  always @(posedge clk_sys) begin
    if (byteValid && byteReady)
      void'(q.pop_front());
    if (!byteValid || byteReady) begin
      if (q.size() > 0 && ($random(seed) & 3) != 0) begin
        byteValid <= 1'b1;
        byteData <= q[0];
      end else begin
        byteValid <= 1'b0;
        byteData <= ~byteData;
      end
    end
  end
endmodule

// file: sim/tb_lid_decoder.sv
`timescale 1ns/1ns
module tb_lid_decoder;
  import lid_pkg::*;
  logic clk_sys, reset, byteValid, byteReady, instrValid, instrReady;
  logic [7:0] byteData, clkMin, clkMax, clkPerCount;
  logic illegal;
  lid_class_t opClass;
  logic [2:0] subOp;
  logic [1:0] segSel;
  logic [25:0] expq[$];
  logic [11:0] clsq[$];
  int fails = 0;
  int testsRun = 0;
  int seed = 32'h8188;
  int k;

  lid_decoder i_lid_decoder (.clk_sys(clk_sys), .reset(reset),
    .byteValid(byteValid), .byteData(byteData), .byteReady(byteReady),
    .instrValid(instrValid), .instrReady(instrReady), .opClass(opClass),
    .opCode(), .subOp(subOp), .opWidth(), .opDir(), .modField(),
    .regField(), .rmField(), .regOperand(), .dispValue(), .immValue(),
    .segOverride(), .segSel(segSel), .repActive(), .repZ(),
    .illegal(illegal),
    .clkMin(clkMin), .clkMax(clkMax), .clkPerCount(clkPerCount));
  lid_byte_source i_lid_byte_source (.clk_sys(clk_sys),
    .byteReady(byteReady), .byteValid(byteValid), .byteData(byteData));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic testDone();
    $display("checks %0d fails %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // bit 25 marks an illegal case whose clocks are not compared
  task automatic send(input int n, input logic [31:0] b,
    input logic [7:0] lo, input logic [7:0] hi,
    input logic [7:0] per = 8'h00, input logic ill = 1'b0,
    input logic [11:0] cs = 12'h000);
    for (int i = 0; i < n; i++)
      i_lid_byte_source.q.push_back(b[8*i +: 8]);
    expq.push_back({ill, ill, lo, hi, per});
    clsq.push_back(cs);
  endtask

  // class note: bit 11 checks segment, bit 10 class and operation
  function automatic logic [11:0] cx(input lid_class_t c,
    input logic [2:0] s);
    return {2'h1, 2'h0, c, s};
  endfunction

  function automatic logic [11:0] sg(input logic [1:0] g,
    input lid_class_t c, input logic [2:0] s);
    return {2'h3, g, c, s};
  endfunction

  task automatic sendc(input int n, input logic [31:0] b,
    input logic [11:0] c, input logic [7:0] lo, input logic [7:0] hi);
    send(n, b, lo, hi, 8'h00, 1'b0, c);
  endtask

  task automatic checkClass(input logic [11:0] e);
    logic [9:0] g;
    g = {segSel, opClass, subOp};
    if (!e[11])
      g[9:8] = e[9:8];
    if (!e[10])
      g[7:0] = e[7:0];
    if (e[11] | e[10]) begin
      testsRun++;
      if (g !== e[9:0]) begin
        fails++;
        $display("mismatch class expected %h seen %h", e[9:0], g);
      end
    end
  endtask

  task automatic checkTiming(input logic [25:0] e);
    logic [24:0] g;
    g = {illegal, clkMin, clkMax, clkPerCount};
    if (e[25])
      g[23:0] = e[23:0];
    testsRun++;
    if (g !== e[24:0]) begin
      fails++;
      $display("mismatch timing expected %h seen %h", e[24:0], g);
    end
  endtask

  always @(posedge clk_sys) begin
    instrReady <= 1'($random(seed));
    if (!reset && instrValid === 1'b1 && instrReady === 1'b1) begin
      if (expq.size() == 0) begin
        fails++;
        $display("mismatch instr expected none seen one");
      end else begin
        checkTiming(expq.pop_front());
        checkClass(clsq.pop_front());
      end
    end
  end

  initial begin
    reset = 1'b1;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    send(2, 32'h40e4, 8'h0a, 8'h0a);
    send(1, 32'hec, 8'h08, 8'h08);
    send(1, 32'hef, 8'h07, 8'h07);
    send(1, 32'hd7, 8'h0b, 8'h0b);
    sendc(2, 32'hd72e, sg(2'h1, CL_TABLE_LOOKUP_BYTE, 3'h0), 8'h0d, 8'h0d);
    send(3, 32'h05468d, 8'h06, 8'h06);
    send(2, 32'hc0c5, 8'h00, 8'h00, 8'h00, 1'b1);
    send(4, 32'h123406c4, 8'h12, 8'h12);
    send(1, 32'h9f, 8'h02, 8'h02);
    send(1, 32'h9e, 8'h03, 8'h03);
    sendc(2, 32'h9c36, sg(2'h2, CL_FLAGS, 3'h0), 8'h0b, 8'h0b);
    sendc(2, 32'h9d3e, sg(2'h3, CL_FLAGS, 3'h1), 8'h0a, 8'h0a);
    sendc(2, 32'h9f26, sg(2'h0, CL_FLAGS, 3'h3), 8'h04, 8'h04);
    send(3, 32'h054600, 8'h0a, 8'h0a);
    send(2, 32'hc001, 8'h03, 8'h03);
    send(2, {16'h0, 8'($random(seed)), 8'h04}, 8'h03, 8'h03);
    send(3, 32'h1234_05, 8'h04, 8'h04);
    send(3, 32'h05f883, 8'h04, 8'h04);
    send(2, 32'hd8f7, 8'h03, 8'h03);
    send(1, 32'h37, 8'h08, 8'h08);
    send(1, 32'h27, 8'h04, 8'h04);
    send(1, 32'h3f, 8'h07, 8'h07);
    send(1, 32'h2f, 8'h04, 8'h04);
    send(2, 32'he0f6, 8'h1a, 8'h1c);
    send(4, 32'h123426f6, 8'h20, 8'h22);
    send(2, 32'hf9f7, 8'h35, 8'h3d);
    send(2, 32'h0ad4, 8'h13, 8'h13);
    send(2, 32'h0ad5, 8'h0f, 8'h0f);
    send(2, 32'h0bd4, 8'h00, 8'h00, 8'h00, 1'b1);
    send(2, 32'hc0d0, 8'h02, 8'h02);
    send(2, 32'he0d2, 8'h05, 8'h05, 8'h01);
    send(1, 32'ha4, 8'h0e, 8'h0e);
    sendc(2, 32'hc01b, cx(CL_ALU, 3'h3), 8'h03, 8'h03);
    sendc(2, 32'h052c, cx(CL_ALU, 3'h5), 8'h03, 8'h03);
    sendc(3, 32'h05c06b, cx(CL_IMUL3, 3'h5), 8'h16, 8'h19);
    sendc(2, 32'he8f7, cx(CL_MULDIV, 3'h5), 8'h22, 8'h25);
    sendc(2, 32'hc031, cx(CL_ALU, 3'h6), 8'h03, 8'h03);
    sendc(3, 32'h05f080, cx(CL_ALU, 3'h6), 8'h04, 8'h04);
    sendc(2, 32'h0534, cx(CL_ALU, 3'h6), 8'h03, 8'h03);
    sendc(2, 32'hc085, cx(CL_TEST, 3'h0), 8'h03, 8'h03);
    sendc(3, 32'h05c0f6, cx(CL_TEST, 3'h2), 8'h04, 8'h04);
    sendc(2, 32'h05a8, cx(CL_TEST, 3'h1), 8'h03, 8'h03);
    sendc(1, 32'hae, cx(CL_STRING, 3'h2), 8'h0f, 8'h0f);
    send(2, 32'ha4f2, 8'h08, 8'h08, 8'h08);
    send(2, 32'haef2, 8'h05, 8'h05, 8'h0f);
    send(2, 32'ha6f3, 8'h05, 8'h05, 8'h16);
    send(1, 32'ha6, 8'h16, 8'h16);
    for (k = 0; k < 5000 && expq.size() > 0; k++)
      @(posedge clk_sys);
    if (k == 5000) begin
      fails++;
      $display("mismatch drain expected 0 seen %0d", expq.size());
    end
    testDone();
  end
endmodule
